/* design/fcpl_defs.vh */
`ifndef FCPL_DEFS_VH
`define FCPL_DEFS_VH

// register byte offsets
`define FCPL_CFG1_NV_OFS 8'h00
`define FCPL_CFG1_V_OFS 8'h04
`define FCPL_CFG2_NV_OFS 8'h08
`define FCPL_CFG2_V_OFS 8'h0C
`define FCPL_STATUS_OFS 8'h10
`define FCPL_LATENCY_OFS 8'h14
`define FCPL_CMD_OFS 8'h18

// config one field positions
`define FCPL_TLOCK_BIT 0
`define FCPL_SECT_TB_BIT 2
`define FCPL_PLOCK_BIT 4
`define FCPL_PROT_TB_BIT 5
`define FCPL_SECT_SPLIT_BIT 6
// config two field positions
`define FCPL_ADDR_LEN_BIT 7
`define FCPL_LAT_MSB 3
`define FCPL_LAT_LSB 0
// status field positions (block protect level in bits 3:1)
`define FCPL_LEVEL_MSB 3
`define FCPL_LEVEL_LSB 1

// reset values
`define FCPL_CFG1_RST 8'h00
`define FCPL_CFG2_RST 8'h08
`define FCPL_STATUS_RST 8'h00
// writable-bit masks; reserved bits always read zero
`define FCPL_CFG1_WMASK 8'h75
`define FCPL_CFG2_WMASK 8'h8F
`define FCPL_PROT_MASK 8'h64
`define FCPL_LEVEL_MASK 8'h0E

// dummy cycle minimums and address byte counts
`define FCPL_LAT_SHORT_MIN 5'd0
`define FCPL_LAT_LONG_MIN 5'd5
`define FCPL_ADDR_BYTES_SHORT 3'd3
`define FCPL_ADDR_BYTES_LONG 3'd4

`endif

/* design/fcpl_config_regs.v */
// Summary of operation
// [RL1] host writes reserved bits as zero; device forces them to zero anyway
// [RL2] temporary lock returns to zero at power-up and hardware reset
// [RL3] temporary lock blocks changes to level, top/bottom and sector bits
// [RL4] temporary lock alone holds until next power-down or reset; here a write of zero to the volatile copy also clears it
// [RL5] permanent lock set locks protected bits forever
// [RL6] temporary lock zero means unprotected, one means temporarily protected
// [RL7] no split: sectors low when top/bottom zero, high when one
// [RL8] split set: sectors at both ends, top/bottom ignored
// [RL9] address-length bit sets address length for all addressed commands
// [RL10] address length zero gives 3 bytes, one gives 4 bytes
// [RL11] latency code sets dummy cycles, resets to 1000
// [RL12] code 0000 gives 0 or 5 cycles by opcode class
// [RL13] code 1111 gives 15 or 28 cycles by opcode class
// [RL14] new latency code applies to subsequent reads
// [RL15] intermediate codes follow the cycle table
// [RL16] locked bits keep their value while unlocked bits in the write update
`timescale 1ns/10ps
`include "fcpl_defs.vh"

module fcpl_config_regs #(
  parameter ADDR_W = 8
) (
  input wire SYS_CLK,
  input wire RESET_N,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output wire HREADYOUT,
  output wire HRESP,
  output reg [31:0] HRDATA,
  input wire LONG_LATENCY_CLASS,
  output wire [4:0] DUMMY_CYCLES,
  output wire [2:0] ADDRESS_BYTES,
  output wire SECTOR_SPLIT,
  output wire SECTOR_AT_TOP,
  output wire SECTOR_AT_BOTTOM,
  output wire PROTECT_LOCKED,
  output wire [2:0] BLOCK_PROTECT_LEVEL,
  output wire PROTECT_TOP_BOTTOM
);

  // config one layout
  //   bit 0 temporary lock, volatile copy only
  //   bit 1 reserved, forced zero
  //   bit 2 sector top/bottom
  //   bit 3 reserved, forced zero
  //   bit 4 permanent lock, set only
  //   bit 5 protect top/bottom
  //   bit 6 sector split
  //   bit 7 reserved, forced zero
  // config two layout
  //   bits 3:0 read latency code
  //   bits 6:4 reserved, forced zero
  //   bit 7 address length select
  // status layout
  //   bits 3:1 block protect level, other bits read zero

  // bus timing
  //   address phase taken when selected, ready and a transfer is signalled
  //   write data lands at the end of the following cycle
  //   read data is captured with the address and shown in the data phase
  //   no wait states, so hreadyout is tied high
  //   size is ignored; each register is one word on byte lane zero

  // lock behaviour
  //   lock state is taken before the write, so a write that sets
  //   the permanent lock still applies its other fields
  //   the temporary lock lives only in the volatile copy and reset clears it
  //   the permanent lock lives in the image, so reset brings it back

  // reset behaviour
  //   synchronous, active low, one edge is enough
  //   volatile copies reload from the images, temporary lock clears
  //   images and status level are kept, they stand in for flash cells

  // architectural state
  reg [7:0] cfg1_nv_q;
  reg [7:0] cfg1_v_q;
  reg [7:0] cfg2_nv_q;
  reg [7:0] cfg2_v_q;
  reg [7:0] status_q;
  reg wr_pend_q;
  reg [ADDR_W-1:0] wr_addr_q;
  // next-state values
  reg [7:0] cfg1_nv_d;
  reg [7:0] cfg1_v_d;
  reg [7:0] cfg2_nv_d;
  reg [7:0] cfg2_v_d;
  reg [7:0] status_d;
  // datapath temporaries
  reg [7:0] wbyte;
  reg [7:0] rd_byte;
  reg [4:0] lat_short;
  reg [4:0] lat_long;
  // decoded state
  wire [3:0] lat_code;
  wire addr_phase;
  wire perm_lock;
  wire temp_lock;
  wire locked;

  // only the volatile copies and the status level steer the device; nonvolatile ones are images
  assign perm_lock = cfg1_v_q[`FCPL_PLOCK_BIT];
  assign temp_lock = cfg1_v_q[`FCPL_TLOCK_BIT];
  // temp lock is a volatile flop cleared by reset or by a volatile write of zero
  assign locked = perm_lock | temp_lock; // [RL3] [RL4] [RL5] [RL6]
  assign PROTECT_LOCKED = locked;

  // sector placement: split wins over top/bottom, so at most one
  // end flag is high, and both are low when split
  // sector placement decode
  assign SECTOR_SPLIT = cfg1_v_q[`FCPL_SECT_SPLIT_BIT]; // [RL8]
  assign SECTOR_AT_TOP = ~SECTOR_SPLIT & cfg1_v_q[`FCPL_SECT_TB_BIT]; // [RL7]
  assign SECTOR_AT_BOTTOM = ~SECTOR_SPLIT & ~cfg1_v_q[`FCPL_SECT_TB_BIT]; // [RL7]
  assign PROTECT_TOP_BOTTOM = cfg1_v_q[`FCPL_PROT_TB_BIT];
  assign BLOCK_PROTECT_LEVEL = status_q[`FCPL_LEVEL_MSB:`FCPL_LEVEL_LSB];

  // address length for every addressed command
  assign ADDRESS_BYTES = cfg2_v_q[`FCPL_ADDR_LEN_BIT] ? `FCPL_ADDR_BYTES_LONG :
                         `FCPL_ADDR_BYTES_SHORT; // [RL9] [RL10]

  // latency table
  //   short column serves the plain reads, long column the rest
  //   above code nine the long column rises one cycle per code
  //   the host must retune the code when it changes clock rate
  // latency table, read live so a new code hits the next read
  assign lat_code = cfg2_v_q[`FCPL_LAT_MSB:`FCPL_LAT_LSB]; // [RL11] [RL14]
  always @* begin
    case (lat_code)
      4'h0: begin
        lat_short = 5'h00; // [RL12]
        lat_long = 5'h05; // [RL12]
      end

      4'h1: begin
        lat_short = 5'h01; // [RL15]
        lat_long = 5'h06; // [RL15]
      end

      4'h2: begin
        lat_short = 5'h02; // [RL15]
        lat_long = 5'h08; // [RL15]
      end

      4'h3: begin
        lat_short = 5'h03; // [RL15]
        lat_long = 5'h0A; // [RL15]
      end

      4'h4: begin
        lat_short = 5'h04; // [RL15]
        lat_long = 5'h0C; // [RL15]
      end

      4'h5: begin
        lat_short = 5'h05; // [RL15]
        lat_long = 5'h0E; // [RL15]
      end

      4'h6: begin
        lat_short = 5'h06; // [RL15]
        lat_long = 5'h10; // [RL15]
      end

      4'h7: begin
        lat_short = 5'h07; // [RL15]
        lat_long = 5'h12; // [RL15]
      end

      4'h8: begin
        lat_short = 5'h08; // [RL15]
        lat_long = 5'h14; // [RL15]
      end

      4'h9: begin
        lat_short = 5'h09; // [RL15]
        lat_long = 5'h16; // [RL15]
      end

      4'hA: begin
        lat_short = 5'h0A; // [RL15]
        lat_long = 5'h17; // [RL15]
      end

      4'hB: begin
        lat_short = 5'h0B; // [RL15]
        lat_long = 5'h18; // [RL15]
      end

      4'hC: begin
        lat_short = 5'h0C; // [RL15]
        lat_long = 5'h19; // [RL15]
      end

      4'hD: begin
        lat_short = 5'h0D; // [RL15]
        lat_long = 5'h1A; // [RL15]
      end

      4'hE: begin
        lat_short = 5'h0E; // [RL15]
        lat_long = 5'h1B; // [RL15]
      end

      default: begin
        lat_short = 5'h0F; // [RL13]
        lat_long = 5'h1C; // [RL13]
      end
    endcase
  end
  assign DUMMY_CYCLES = LONG_LATENCY_CLASS ? lat_long : lat_short; // [RL12] [RL13]

  // ahb slave: zero wait states, always okay
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign addr_phase = HSEL & HREADY & HTRANS[1];

  // masked merge: locked fields keep old value, others take the write
  always @* begin
    wbyte = HWDATA[7:0];
    cfg1_nv_d = cfg1_nv_q;
    cfg1_v_d = cfg1_v_q;
    cfg2_nv_d = cfg2_nv_q;
    cfg2_v_d = cfg2_v_q;
    status_d = status_q;
    if (wr_pend_q) begin
      case (wr_addr_q)
        `FCPL_CFG1_NV_OFS: begin
          // reserved bits dropped so they stay zero
          cfg1_nv_d = wbyte & `FCPL_CFG1_WMASK; // [RL1]
          // temp lock has no nonvolatile image
          cfg1_nv_d[`FCPL_TLOCK_BIT] = 1'b0;
          if (locked) begin
            cfg1_nv_d = (cfg1_nv_d & ~`FCPL_PROT_MASK) |
                        (cfg1_nv_q & `FCPL_PROT_MASK); // [RL16]
          end
          // permanent lock only goes one way
          cfg1_nv_d[`FCPL_PLOCK_BIT] = cfg1_nv_q[`FCPL_PLOCK_BIT] |
                                       wbyte[`FCPL_PLOCK_BIT]; // [RL5]
          cfg1_v_d = (cfg1_v_q & (8'h01)) | (cfg1_nv_d & 8'hFE);
        end
        `FCPL_CFG1_V_OFS: begin
          // volatile copy: temp lock writable, protected bits read-only
          cfg1_v_d[`FCPL_TLOCK_BIT] = wbyte[`FCPL_TLOCK_BIT]; // [RL6]
        end
        `FCPL_CFG2_NV_OFS: begin
          cfg2_nv_d = wbyte & `FCPL_CFG2_WMASK; // [RL1]
          cfg2_v_d = cfg2_nv_d;
        end
        `FCPL_CFG2_V_OFS: begin
          cfg2_v_d = wbyte & `FCPL_CFG2_WMASK; // [RL1] [RL14]
        end
        `FCPL_STATUS_OFS: begin
          if (!locked) begin
            status_d = wbyte & `FCPL_LEVEL_MASK; // [RL3]
          end
        end
        default: begin
          status_d = status_q;
        end
      endcase
    end
  end

  // register state; reset reloads volatile copies from nonvolatile images
  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= {ADDR_W{1'b0}};
      cfg1_v_q <= {cfg1_nv_q[7:1], 1'b0}; // [RL2]
      cfg2_v_q <= cfg2_nv_q;
    end else begin
      wr_pend_q <= addr_phase & HWRITE;
      if (addr_phase) begin
        wr_addr_q <= HADDR[ADDR_W-1:0];
      end
      cfg1_v_q <= cfg1_v_d;
      cfg2_v_q <= cfg2_v_d;
    end
  end

  // nonvolatile images survive the hardware reset; factory values at start
  initial begin
    cfg1_nv_q = `FCPL_CFG1_RST;
    cfg2_nv_q = `FCPL_CFG2_RST;
    status_q = `FCPL_STATUS_RST;
  end
  always @(posedge SYS_CLK) begin
    cfg1_nv_q <= cfg1_nv_d;
    cfg2_nv_q <= cfg2_nv_d;
    status_q <= status_d;
  end

  // read mux, sampled at address phase into the data-phase register
  always @* begin
    case (HADDR[ADDR_W-1:0])
      `FCPL_CFG1_NV_OFS: begin
        rd_byte = cfg1_nv_q;
      end
      `FCPL_CFG1_V_OFS: begin
        rd_byte = cfg1_v_q;
      end
      `FCPL_CFG2_NV_OFS: begin
        rd_byte = cfg2_nv_q;
      end
      `FCPL_CFG2_V_OFS: begin
        rd_byte = cfg2_v_q;
      end
      `FCPL_STATUS_OFS: begin
        rd_byte = status_q;
      end
      `FCPL_LATENCY_OFS: begin
        rd_byte = {3'b000, DUMMY_CYCLES};
      end
      `FCPL_CMD_OFS: begin
        rd_byte = {2'b00, locked, SECTOR_SPLIT, SECTOR_AT_TOP,
                   ADDRESS_BYTES};
      end
      // unmapped offsets read zero; the host sees no error response
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // read data register, held until the next read address phase
  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      HRDATA <= 32'h0000_0000;
    end else if (addr_phase & ~HWRITE) begin
      HRDATA <= {24'h00_0000, rd_byte};
    end
  end

endmodule

/* tb/fcpl_sva.sv */
`timescale 1ns/10ps
module fcpl_sva (
  input wire SYS_CLK,
  input wire RESET_N,
  input wire HSEL,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire LONG_LATENCY_CLASS,
  input wire [4:0] DUMMY_CYCLES,
  input wire [2:0] ADDRESS_BYTES,
  input wire SECTOR_SPLIT,
  input wire SECTOR_AT_TOP,
  input wire SECTOR_AT_BOTTOM,
  input wire PROTECT_LOCKED,
  input wire [2:0] BLOCK_PROTECT_LEVEL,
  input wire PROTECT_TOP_BOTTOM
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);
  // latency (with the class held) and address length only move two edges after a write address phase
  property p_lat;
    $changed(DUMMY_CYCLES) && $stable(LONG_LATENCY_CLASS) |-> $past(HSEL && HTRANS[1] && HWRITE, 2);
  endproperty
  a_lat: assert property (p_lat) else $error("latency moved without write");
  property p_alen;
    $changed(ADDRESS_BYTES) |-> $past(HSEL && HTRANS[1] && HWRITE, 2);
  endproperty
  a_alen: assert property (p_alen) else $error("address length moved without write");
  property p_abytes;
    ADDRESS_BYTES == 3'h3 || ADDRESS_BYTES == 3'h4;
  endproperty
  a_abytes: assert property (p_abytes) else $error("address bytes not 3 or 4");
  property p_split;
    SECTOR_SPLIT |-> !SECTOR_AT_TOP && !SECTOR_AT_BOTTOM;
  endproperty
  a_split: assert property (p_split) else $error("split sectors placed at one end");
  property p_ends;
    !SECTOR_SPLIT |-> SECTOR_AT_TOP != SECTOR_AT_BOTTOM;
  endproperty
  a_ends: assert property (p_ends) else $error("grouped sectors not at one end");
  property p_short;
    !LONG_LATENCY_CLASS |-> DUMMY_CYCLES <= 5'h0F;
  endproperty
  a_short: assert property (p_short) else $error("short latency above 15");
  property p_long;
    LONG_LATENCY_CLASS |-> DUMMY_CYCLES >= 5'h05 && DUMMY_CYCLES <= 5'h1C;
  endproperty
  a_long: assert property (p_long) else $error("long latency outside 5 to 28");
  // reset reload is excluded, it restores the same locked image
  property p_lock;
    PROTECT_LOCKED |=> $stable({BLOCK_PROTECT_LEVEL, SECTOR_SPLIT, SECTOR_AT_TOP, PROTECT_TOP_BOTTOM});
  endproperty
  a_lock: assert property (p_lock) else $error("protected field changed while locked");
endmodule
bind fcpl_config_regs fcpl_sva u_sva (.*);

/* tb/fcpl_host_model.sv */
`timescale 1ns/10ps
module fcpl_host_model (
  input wire SYS_CLK,
  input wire HREADY,
  input wire [31:0] HRDATA,
  output logic HSEL,
  output logic [31:0] HADDR,
  output logic [1:0] HTRANS,
  output logic HWRITE,
  output logic [2:0] HSIZE,
  output logic [31:0] HWDATA
);
  int tmo = 0;
  // idle bus at time zero
  initial begin
    HSEL = 1'b0;
    HADDR = 32'h0000_0000;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0000_0000;
  end
  // bounded wait so a stuck slave cannot hang the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (HREADY !== 1'b1 && n < 50);
    if (n >= 50) tmo++;
  endtask
  // single word transfer, byte lane zero carries the register
  task automatic xfer(input bit w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    HSEL <= 1'b1;
    HADDR <= {24'h00_0000, a};
    HTRANS <= 2'h2;
    HWRITE <= w;
    wait_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= {24'h00_0000, d};
    wait_rdy();
    r = HRDATA[7:0];
  endtask
endmodule

/* tb/fcpl_config_regs_tb.sv */
`timescale 1ns/10ps
`include "fcpl_defs.vh"
module fcpl_config_regs_tb;
  logic SYS_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic LONG_LATENCY_CLASS = 1'b0;
  wire HSEL, HWRITE, HREADY, HREADYOUT, HRESP;
  wire SECTOR_SPLIT, SECTOR_AT_TOP, SECTOR_AT_BOTTOM, PROTECT_LOCKED, PROTECT_TOP_BOTTOM;
  wire [31:0] HADDR, HWDATA, HRDATA;
  wire [1:0] HTRANS;
  wire [2:0] HSIZE, ADDRESS_BYTES, BLOCK_PROTECT_LEVEL;
  wire [4:0] DUMMY_CYCLES;
  int fail_count = 0;
  int n_checks = 0;
  logic [7:0] rv;
  logic [4:0] lt [16] = '{5'h05, 5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h12,
                          5'h14, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C};
  assign HREADY = HREADYOUT;
  fcpl_config_regs u_dut (.*);
  fcpl_host_model u_host (.*);
  always #20 SYS_CLK = ~SYS_CLK;
  // a stalled transfer ends the run as a mismatch
  always @(posedge SYS_CLK) if (u_host.tmo > 0) begin
    fail_count++;
    results();
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // extra edge so combinational outputs have settled before a check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d, rv);
    @(posedge SYS_CLK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
    u_host.xfer(1'b0, a, 8'h00, rv);
    chk(rv, e, what);
  endtask
  task automatic do_reset();
    RESET_N <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    @(posedge SYS_CLK);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    do_reset();
    rd(`FCPL_CFG2_V_OFS, 8'h08, "cfg2 default");
    rd(`FCPL_CFG1_V_OFS, 8'h00, "cfg1 default");
    rd(8'h1C, 8'h00, "unmapped");
    // every latency code in both classes, address length toggling
    for (int c = 0; c < 16; c++) begin
      wr(`FCPL_CFG2_V_OFS, {c[0], 3'h0, c[3:0]});
      LONG_LATENCY_CLASS <= 1'b0;
      @(posedge SYS_CLK);
      chk(8'(DUMMY_CYCLES), 8'(c), "short latency");
      LONG_LATENCY_CLASS <= 1'b1;
      @(posedge SYS_CLK);
      chk(8'(DUMMY_CYCLES), 8'(lt[c]), "long latency");
      chk(8'(ADDRESS_BYTES), c[0] ? 8'h04 : 8'h03, "address bytes");
    end
    for (int i = 0; i < 4; i++) begin
      wr(`FCPL_CFG1_NV_OFS, {1'b0, i[1], 3'h0, i[0], 2'h0});
      chk({5'h00, SECTOR_SPLIT, SECTOR_AT_TOP, SECTOR_AT_BOTTOM},
          i[1] ? 8'h04 : (i[0] ? 8'h02 : 8'h01), "sector place");
    end
    wr(`FCPL_CFG1_V_OFS, 8'h01);
    chk(8'(PROTECT_LOCKED), 8'h01, "temp lock");
    wr(`FCPL_STATUS_OFS, 8'h0E);
    chk(8'(BLOCK_PROTECT_LEVEL), 8'h00, "level locked");
    do_reset();
    chk(8'(PROTECT_LOCKED), 8'h00, "lock after reset");
    wr(`FCPL_STATUS_OFS, 8'h0E);
    chk(8'(BLOCK_PROTECT_LEVEL), 8'h07, "level unlocked");
    wr(`FCPL_CFG1_V_OFS, 8'h01);
    wr(`FCPL_CFG1_NV_OFS, 8'h30);
    rd(`FCPL_CFG1_V_OFS, 8'h55, "partial locked write");
    chk(8'(PROTECT_TOP_BOTTOM), 8'h00, "protect top bottom locked");
    do_reset();
    rd(`FCPL_CFG1_V_OFS, 8'h54, "perm lock kept");
    chk(8'(PROTECT_LOCKED), 8'h01, "perm lock");
    wr(`FCPL_STATUS_OFS, 8'h00);
    chk(8'(BLOCK_PROTECT_LEVEL), 8'h07, "level perm locked");
    rd(`FCPL_LATENCY_OFS, 8'h14, "latency register");
    rd(`FCPL_CMD_OFS, 8'h33, "summary register");
    chk(8'(HRESP), 8'h00, "hresp okay");
    chk(8'(HREADYOUT), 8'h01, "hreadyout");
    results();
  end
endmodule
